// file: motor_speed_search_sequencer_test.sv
`default_nettype none
module motor_speed_search_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, resetn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [5:0]  wb_adr_i = 6'h0;
    logic [3:0]  wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    logic        input_a = 0, input_b = 0, run_cmd = 0, power_loss_restart = 0;
    logic        loss_freq_valid = 1, slow = 0;
    logic [7:0]  fsa = 8'h0, fsb = 8'h0;
    logic [15:0] set_freq = 16'h0fa0, loss_freq = 16'h1388;
    wire  [31:0] wb_dat_o;
    wire  [15:0] start_freq, est_freq, encoder_freq;
    wire  [7:0]  output_current;
    wire         wb_ack_o, irq, output_enable, search_active, start_reverse, ramp_to_set;
    wire         est_reverse, input_selection_conflict_error;
    int          err_count = 0, num_checks = 0;
    localparam int TK = 4;
    always #10 clk = ~clk;
    mss_search_seq #(.TICK_CYCLES(32'd4)) DUT (
        .clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .irq, .input_a, .input_b, .run_cmd, .power_loss_restart,
        .input_terminal_function_select_a(fsa), .input_terminal_function_select_b(fsb),
        .set_freq, .est_freq, .est_reverse, .encoder_freq, .loss_freq, .loss_freq_valid,
        .output_current, .output_enable, .search_active, .start_freq, .start_reverse,
        .ramp_to_set, .input_selection_conflict_error);
    mss_motor_model u_motor (.clk, .resetn, .output_enable, .slow, .output_current,
        .est_freq, .est_reverse, .encoder_freq);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [3:0] i, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        @(posedge clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, i, 2'h0, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 20);
        if (wb_ack_o !== 1'h1) begin
            err_count++;
            conclude;
        end
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask
    // Bounded wait on output enable or on the ramp
    task automatic wait_on(input logic rts, output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((rts ? ramp_to_set : output_enable) !== 1'h1 && n < 400);
        if (n >= 400) begin
            err_count++;
            conclude;
        end
    endtask
    task automatic t_regs;
        logic [31:0] q;
        logic [31:0] e [10] = '{32'h0, 32'h2, 32'h5, 32'h64, 32'h1770, 32'h0, 32'h0,
                                32'h0, 32'h0, 32'h0};
        wb(1'h1, 4'h9, 32'h55, q);
        for (int i = 0; i < 10; i++) begin
            wb(1'h0, i[3:0], 32'h0, q);
            check(q, e[i]);
        end
        wb(1'h1, 4'h1, 32'hff, q);
        wb(1'h0, 4'h1, 32'h0, q);
        check(q, 32'hc8);
        wb(1'h1, 4'h2, 32'h0, q);
        wb(1'h0, 4'h2, 32'h0, q);
        check(q, 32'h1);
        wb(1'h1, 4'h2, 32'h40, q);
        wb(1'h0, 4'h2, 32'h0, q);
        check(q, 32'h32);
        wb(1'h1, 4'h2, 32'h1, q);
    endtask
    task automatic t_search(input logic [7:0] ctrl, input logic [7:0] f, input logic ina, pl,
                            input logic [7:0] w, input logic [15:0] ef, input logic er);
        logic [31:0] q;
        int n;
        wb(1'h1, 4'h0, {24'h0, ctrl}, q);
        // Power-loss restart adds one tick of minimum off time
        wb(1'h1, 4'h1, {24'h0, w - pl}, q);
        fsa <= f;
        @(posedge clk);
        {run_cmd, input_a, power_loss_restart} <= {1'h1, ina, pl};
        wait_on(1'h0, n);
        check(n >= int'(w) * TK - TK && n <= int'(w) * TK + TK, 1'h1);
        check(start_freq, ef);
        if (er !== 1'hx)
            check(start_reverse, er);
        wait_on(1'h1, n);
        check(search_active, 1'h0);
        // Run and search held well past the minimum off time
        @(posedge clk);
        {run_cmd, input_a, power_loss_restart} <= 3'h0;
        repeat (4) @(posedge clk);
    endtask
    task automatic t_nosearch(input logic [7:0] ctrl, input logic [7:0] f);
        logic [31:0] q;
        int n;
        wb(1'h1, 4'h0, {24'h0, ctrl}, q);
        fsa <= f;
        @(posedge clk);
        {run_cmd, input_a} <= {1'h1, f != 8'h0};
        wait_on(1'h0, n);
        check(start_freq, 16'h0);
        check(search_active, 1'h0);
        @(posedge clk);
        {run_cmd, input_a} <= 2'h0;
        repeat (4) @(posedge clk);
    endtask
    task automatic t_irq;
        logic [31:0] q;
        wb(1'h1, 4'h7, 32'h4, q);
        wb(1'h0, 4'h6, 32'h0, q);
        check(q, 32'h3);
        {fsa, fsb} <= 16'h3d3e;
        repeat (2) @(negedge clk);
        check(input_selection_conflict_error, 1'h1);
        check(irq, 1'h1);
        @(posedge clk);
        fsb <= 8'h0;
        wb(1'h0, 4'h6, 32'h0, q);
        check(q[2], 1'h1);
        wb(1'h0, 4'h6, 32'h0, q);
        check(q, 32'h0);
        @(negedge clk);
        check(irq, 1'h0);
        wb(1'h1, 4'h7, 32'h0, q);
        fsb <= 8'h3e;
        repeat (2) @(negedge clk);
        check(irq, 1'h0);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'h1;
        t_regs;
        slow <= 1'h1;
        t_search(8'h02, 8'h3d, 1'h1, 1'h0, 8'h2, 16'h1770, 1'h0);
        slow <= 1'h0;
        t_search(8'h02, 8'h3e, 1'h1, 1'h0, 8'h0, set_freq, 1'h0);
        t_search(8'h0a, 8'h3e, 1'h1, 1'h0, 8'h2, set_freq, 1'h0);
        t_search(8'h00, 8'h3d, 1'h1, 1'h0, 8'h2, est_freq, 1'h1);
        t_search(8'h00, 8'h3e, 1'h1, 1'h0, 8'h2, est_freq, 1'h1);
        t_search(8'h25, 8'h00, 1'h0, 1'h0, 8'h2, encoder_freq, 1'hx);
        t_search(8'h02, 8'h00, 1'h0, 1'h1, 8'h1, loss_freq, 1'h0);
        loss_freq_valid <= 1'h0;
        t_search(8'h02, 8'h00, 1'h0, 1'h1, 8'h1, 16'h1770, 1'h0);
        t_nosearch(8'h00, 8'h00);
        t_nosearch(8'h02, 8'h00);
        t_nosearch(8'h06, 8'h3e);
        t_irq;
        conclude;
    end
endmodule // motor_speed_search_sequencer_test
bind mss_search_seq mss_search_chk u_chk (.clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .wb_dat_o, .input_terminal_function_select_a, .input_terminal_function_select_b,
    .output_enable, .search_active, .start_freq, .ramp_to_set,
    .input_selection_conflict_error);
`default_nettype wire

// file: mss_consts.vh
`ifndef MSS_CONSTS_VH
`define MSS_CONSTS_VH
// Register word indices
`define MSS_REG_CTRL      4'h0
`define MSS_REG_WAIT      4'h1
`define MSS_REG_MINBB     4'h2
`define MSS_REG_CURLVL    4'h3
`define MSS_REG_FMAX      4'h4
`define MSS_REG_STATUS    4'h5
`define MSS_REG_IRQ_STAT  4'h6
`define MSS_REG_IRQ_MASK  4'h7
`define MSS_REG_FSTART    4'h8
// Input function codes
`define MSS_FUNC_SEARCH1  8'h3d
`define MSS_FUNC_SEARCH2  8'h3e
// Control field positions
`define MSS_CTRL_TYPE_LSB 0
`define MSS_CTRL_METH_LSB 2
`define MSS_CTRL_ENC      5
// Search type select values
`define MSS_SEL_EST_START 2'h1
`define MSS_SEL_CUR_START 2'h3
// Control methods
`define MSS_METH_VF       3'h0
`define MSS_METH_VF_ENC   3'h1
`define MSS_METH_OLV1     3'h2
`define MSS_METH_FLUX     3'h3
`define MSS_METH_OLV2     3'h4
// Times in units of 0.1 s, then the current level and maximum frequency defaults
`define MSS_WAIT_DEFAULT  8'h02
`define MSS_WAIT_MAX      8'hc8
`define MSS_MINBB_DEFAULT 8'h05
`define MSS_MINBB_MIN     8'h01
`define MSS_MINBB_MAX     8'h32
`define MSS_CURLVL_DEFAULT 8'h64
`define MSS_FMAX_DEFAULT  16'h1770
// Tick period in ms, and clock in kHz
`define MSS_TICK_MS       100
`define MSS_CLK_KHZ       50000
`define MSS_TICK_CYCLES   (`MSS_TICK_MS * `MSS_CLK_KHZ)
`endif

// file: mss_motor_model.sv
`default_nettype none
module mss_motor_model (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        output_enable,
    input  wire logic        slow,
    output var  logic [7:0]  output_current,
    output var  logic [15:0] est_freq,
    output var  logic        est_reverse,
    output var  logic [15:0] encoder_freq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt;
    // Coasting rotor, turning backwards
    assign est_freq = 16'h0bb8;
    assign est_reverse = 1'h1;
    assign encoder_freq = 16'h0a28;
    always @(posedge clk or negedge resetn) begin
        if (!resetn)
            cnt <= 4'h0;
        else if (!output_enable)
            cnt <= 4'h0;
        else if (cnt != 4'hf)
            cnt <= cnt + 4'h1;
    end
    // Slip current high until output catches the rotor
    assign output_current = !output_enable ? 8'h00 :
        (cnt < (slow ? 4'hc : 4'h2)) ? 8'h96 : 8'h1e;
endmodule // mss_motor_model
`default_nettype wire

// file: mss_search_chk.sv
`default_nettype none
module mss_search_chk (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic [7:0]  input_terminal_function_select_a,
    input wire logic [7:0]  input_terminal_function_select_b,
    input wire logic        output_enable,
    input wire logic        search_active,
    input wire logic [15:0] start_freq,
    input wire logic        ramp_to_set,
    input wire logic        input_selection_conflict_error
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire [7:0] fa = input_terminal_function_select_a;
    wire [7:0] fb = input_terminal_function_select_b;
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_read_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o))
        else $error("read data moved between reads");
    a_conflict_flag: assert property (input_selection_conflict_error ==
        (fa == 8'h3d && fb == 8'h3e || fa == 8'h3e && fb == 8'h3d))
        else $error("conflict flag wrong");
    a_search_drives: assert property (search_active |-> output_enable)
        else $error("search without output");
    a_ramp_cause: assert property ($rose(ramp_to_set) |->
        $past(search_active) || start_freq == 16'h0)
        else $error("ramp without search");
    a_freq_hold: assert property (search_active && $past(search_active) |->
        $stable(start_freq))
        else $error("start frequency moved in search");
endmodule // mss_search_chk
`default_nettype wire

// file: mss_search_seq.v
// How it works
// [R01] Input function 61 starts a search from maximum output frequency.
// [R02] Input function 62 searches from set frequency; not with encoder or flux.
// [R03] Both search functions assigned together flags an input selection conflict.
// [R04] V/f with encoder and startup search starts from encoder frequency.
// [R05] Outside sequence holds run and search together for minimum off time.
// [R06] Every search waits the search wait time first; zero means none.
// [R07] Current search completes when current drops below level, then ramps.
// [R08] Run-command search only when type select is 1 or 3.
// [R09] Estimated search starts from estimated speed and direction; after a power loss the code starts from loss_freq or max_freq, forward.
// [R10] Current search after power loss starts from held or maximum frequency.
// [R11] Estimated mode treats both search inputs alike, from estimated speed.
// [R12] Current mode input 62 starts from reference held before assertion.
// [R13] Search wait time settable 0.0 to 20.0 seconds.
// [R14] Minimum off time settable 0.1 to 5.0 seconds.
// [R15] No search selected and no input: start from zero frequency.
`default_nettype none
`include "mss_consts.vh"
module mss_search_seq #(
    parameter [31:0] TICK_CYCLES = `MSS_TICK_CYCLES
) (
    input  wire        clk,
    input  wire        resetn,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [5:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output wire        irq,
    input  wire [7:0]  input_terminal_function_select_a,
    input  wire [7:0]  input_terminal_function_select_b,
    input  wire        input_a,
    input  wire        input_b,
    input  wire        run_cmd,
    input  wire        power_loss_restart,
    input  wire [15:0] set_freq,
    input  wire [15:0] est_freq,
    input  wire        est_reverse,
    input  wire [15:0] encoder_freq,
    input  wire [15:0] loss_freq,
    input  wire        loss_freq_valid,
    input  wire [7:0]  output_current,
    output reg         output_enable,
    output reg         search_active,
    output reg  [15:0] start_freq,
    output reg         start_reverse,
    output reg         ramp_to_set,
    output wire        input_selection_conflict_error
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_BB   = 3'h1;
    localparam [2:0] ST_WAIT = 3'h2;
    localparam [2:0] ST_SRCH = 3'h3;
    localparam [2:0] ST_RUN  = 3'h4;

    reg  [31:0] ctrl;
    reg  [7:0]  search_wait_time;
    reg  [7:0]  min_output_off_time;
    reg  [7:0]  search_current_level;
    reg  [15:0] max_freq;
    reg  [2:0]  irq_stat;
    reg  [2:0]  irq_mask;
    reg  [2:0]  state;
    reg  [7:0]  tcount;
    reg  [15:0] ref_hold;
    reg         run_q;
    reg         ext1_q;
    reg         ext2_q;
    wire        tick;

    mss_tick_div #(.PERIOD(TICK_CYCLES)) u_div (
        .clk    (clk),
        .resetn (resetn),
        .tick   (tick)
    );

    function sel_is;
        input [7:0] code;
        input [7:0] func;
        sel_is = (code == func);
    endfunction

    wire [1:0] type_sel = ctrl[`MSS_CTRL_TYPE_LSB+1:`MSS_CTRL_TYPE_LSB];
    wire [2:0] method   = ctrl[`MSS_CTRL_METH_LSB+2:`MSS_CTRL_METH_LSB];
    wire       enc_used = (method == `MSS_METH_VF_ENC) || (method == `MSS_METH_FLUX);
    wire       est_mode = (type_sel == `MSS_SEL_EST_START) || (type_sel == 2'h0);
    wire       startup_search = (type_sel == `MSS_SEL_EST_START) ||
                                (type_sel == `MSS_SEL_CUR_START);              // see [R08]
    wire ext1_on = (sel_is(input_terminal_function_select_a, `MSS_FUNC_SEARCH1) && input_a) ||
                   (sel_is(input_terminal_function_select_b, `MSS_FUNC_SEARCH1) && input_b);
    wire ext2_on = ((sel_is(input_terminal_function_select_a, `MSS_FUNC_SEARCH2) && input_a) ||
                   (sel_is(input_terminal_function_select_b, `MSS_FUNC_SEARCH2) && input_b))
                   && !enc_used;                                               // see [R02]
    wire f1_assigned = sel_is(input_terminal_function_select_a, `MSS_FUNC_SEARCH1) ||
                       sel_is(input_terminal_function_select_b, `MSS_FUNC_SEARCH1);
    wire f2_assigned = sel_is(input_terminal_function_select_a, `MSS_FUNC_SEARCH2) ||
                       sel_is(input_terminal_function_select_b, `MSS_FUNC_SEARCH2);
    assign input_selection_conflict_error = f1_assigned && f2_assigned;       // see [R03]

    wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire [3:0] reg_idx = wb_adr_i[5:2];
    wire run_rise = run_cmd && !run_q;
    wire ext_rise = (ext1_on && !ext1_q) || (ext2_on && !ext2_q);
    wire cur_low  = output_current < search_current_level;
    wire ev_start = (state == ST_IDLE) && run_rise;
    wire ev_done  = (state == ST_SRCH) && (est_mode || cur_low);
    wire [2:0] ev = {input_selection_conflict_error, ev_done, ev_start};
    assign irq = |(irq_stat & irq_mask);

    // Read value for the bus
    reg [31:0] rd;
    always @* begin
        rd = 32'h0;
        case (reg_idx)
            `MSS_REG_CTRL:     rd = ctrl;
            `MSS_REG_WAIT:     rd = {24'h0, search_wait_time};
            `MSS_REG_MINBB:    rd = {24'h0, min_output_off_time};
            `MSS_REG_CURLVL:   rd = {24'h0, search_current_level};
            `MSS_REG_FMAX:     rd = {16'h0, max_freq};
            `MSS_REG_STATUS:   rd = {26'h0, input_selection_conflict_error, state, search_active,
                                     output_enable};
            `MSS_REG_IRQ_STAT: rd = {29'h0, irq_stat};
            `MSS_REG_IRQ_MASK: rd = {29'h0, irq_mask};
            `MSS_REG_FSTART:   rd = {15'h0, start_reverse, start_freq};
            default:           rd = 32'h0;
        endcase
    end

    // Bus slave: one wait-free ack, unmapped reads zero
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wb_ack_o             <= 1'b0;
            wb_dat_o             <= 32'h0;
            ctrl                 <= 32'h0;
            search_wait_time     <= `MSS_WAIT_DEFAULT;
            min_output_off_time  <= `MSS_MINBB_DEFAULT;
            search_current_level <= `MSS_CURLVL_DEFAULT;
            max_freq             <= `MSS_FMAX_DEFAULT;
            irq_mask             <= 3'h0;
            irq_stat             <= 3'h0;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                wb_dat_o <= rd;
            end
            if (bus_req && wb_we_i && wb_sel_i[0]) begin
                case (reg_idx)
                    `MSS_REG_CTRL:     ctrl[7:0] <= wb_dat_i[7:0];
                    `MSS_REG_WAIT: begin
                        // Clamp keeps the wait inside 0.0 to 20.0 s
                        search_wait_time <= (wb_dat_i[7:0] > `MSS_WAIT_MAX) ?
                                            `MSS_WAIT_MAX : wb_dat_i[7:0];       // see [R13]
                    end
                    `MSS_REG_MINBB: begin
                        if (wb_dat_i[7:0] < `MSS_MINBB_MIN)
                            min_output_off_time <= `MSS_MINBB_MIN;              // see [R14]
                        else if (wb_dat_i[7:0] > `MSS_MINBB_MAX)
                            min_output_off_time <= `MSS_MINBB_MAX;
                        else
                            min_output_off_time <= wb_dat_i[7:0];
                    end
                    `MSS_REG_CURLVL:   search_current_level <= wb_dat_i[7:0];
                    `MSS_REG_FMAX:     max_freq[7:0] <= wb_dat_i[7:0];
                    `MSS_REG_IRQ_MASK: irq_mask <= wb_dat_i[2:0];
                    default: ;
                endcase
            end
            if (bus_req && wb_we_i && wb_sel_i[1] && reg_idx == `MSS_REG_FMAX) begin
                max_freq[15:8] <= wb_dat_i[15:8];
            end
            // Set wins over the read clear
            if (bus_req && !wb_we_i && reg_idx == `MSS_REG_IRQ_STAT)
                irq_stat <= ev;
            else
                irq_stat <= irq_stat | ev;
        end
    end

    // Search sequencer
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state         <= ST_IDLE;
            tcount        <= 8'h0;
            run_q         <= 1'b0;
            ext1_q        <= 1'b0;
            ext2_q        <= 1'b0;
            ref_hold      <= 16'h0;
            output_enable <= 1'b0;
            search_active <= 1'b0;
            start_freq    <= 16'h0;
            start_reverse <= 1'b0;
            ramp_to_set   <= 1'b0;
        end else begin
            run_q  <= run_cmd;
            ext1_q <= ext1_on;
            ext2_q <= ext2_on;
            // Reference latched while command 2 is off, so it predates the command
            if (!ext2_on)
                ref_hold <= set_freq;                                           // see [R12]
            case (state)
                ST_IDLE: begin
                    output_enable <= 1'b0;
                    ramp_to_set   <= 1'b0;
                    if (run_cmd && power_loss_restart) begin
                        state  <= ST_BB;
                        tcount <= 8'h0;
                        start_freq <= loss_freq_valid ? loss_freq : max_freq;   // see [R10]
                        // Direction from an earlier estimate must not leak in
                        start_reverse <= 1'b0;
                    end else if (run_cmd && (ext1_on || ext2_on || startup_search)) begin
                        state  <= ST_WAIT;
                        tcount <= 8'h0;
                        start_reverse <= 1'b0;
                        // Encoder speed beats the estimate on a plain startup search
                        if (method == `MSS_METH_VF_ENC && ctrl[`MSS_CTRL_ENC] &&
                            !ext1_on && !ext2_on)
                            start_freq <= encoder_freq;                         // see [R04]
                        else if (est_mode) begin
                            start_freq    <= est_freq;                          // see [R09]
                            start_reverse <= est_reverse;                       // see [R11]
                        end else if (ext1_on)
                            start_freq <= max_freq;                             // see [R01]
                        else if (ext2_on)
                            start_freq <= ref_hold;                             // see [R12]
                        else
                            start_freq <= max_freq;
                    end else if (run_rise) begin
                        state         <= ST_RUN;
                        start_freq    <= 16'h0;                                 // see [R15]
                        start_reverse <= 1'b0;
                        output_enable <= 1'b1;
                        ramp_to_set   <= 1'b1;
                    end
                end
                ST_BB: begin
                    // Output held off for the minimum off time after a loss
                    if (tick)
                        tcount <= tcount + 8'h1;
                    if (tcount >= min_output_off_time) begin
                        state  <= ST_WAIT;
                        tcount <= 8'h0;
                    end
                end
                ST_WAIT: begin
                    if (!run_cmd) begin
                        state <= ST_IDLE;
                    end else if (tcount >= search_wait_time) begin
                        state         <= ST_SRCH;                               // see [R06]
                        search_active <= 1'b1;
                        output_enable <= 1'b1;
                    end else if (tick) begin
                        tcount <= tcount + 8'h1;
                    end
                end
                ST_SRCH: begin
                    if (!run_cmd) begin
                        state         <= ST_IDLE;
                        search_active <= 1'b0;
                    end else if (ev_done) begin
                        state         <= ST_RUN;                                // see [R07]
                        search_active <= 1'b0;
                        ramp_to_set   <= 1'b1;
                    end
                end
                ST_RUN: begin
                    if (!run_cmd) begin
                        state         <= ST_IDLE;
                        output_enable <= 1'b0;
                        ramp_to_set   <= 1'b0;
                    end else if (ext_rise) begin
                        // Relies on the outside sequence holding run and search
                        state         <= ST_IDLE;                               // see [R05]
                        output_enable <= 1'b0;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule // mss_search_seq
`default_nettype wire

// file: mss_tick_div.v
`default_nettype none
// Divider producing one-cycle tick enables
module mss_tick_div #(
    parameter [31:0] PERIOD = 32'd5000000
) (
    input  wire        clk,
    input  wire        resetn,
    output reg         tick
);
    reg [31:0] count;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count <= 32'h0;
            tick  <= 1'b0;
        end else if (count >= PERIOD - 32'd1) begin
            count <= 32'h0;
            tick  <= 1'b1;
        end else begin
            count <= count + 32'd1;
            tick  <= 1'b0;
        end
    end
endmodule // mss_tick_div
`default_nettype wire
